// >>> design/alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the AXI4-Lite port.
`define ALU_OFS_FLAGS     8'h00
`define ALU_OFS_RESULT    8'h04
`define ALU_OFS_STATUS    8'h08

////////////////////////////////////////////////////////////////////////////
// Field positions and reset values.
`define ALU_FLAGS_W       5
`define ALU_FLAGS_RST     5'h00
`define ALU_STAT_BUSY     0
`define ALU_RESP_OKAY     2'h0
`define ALU_RESP_SLVERR   2'h2

////////////////////////////////////////////////////////////////////////////
// Operand alignment shifts, decimal adjust and divider timing.
`define ALU_SH_B          5'h18
`define ALU_SH_W          5'h10
`define ALU_SH_L          5'h00
`define ALU_BCD_DIGIT_MAX 4'h9
`define ALU_BCD_BYTE_MAX  8'h99
`define ALU_BCD_FIX       4'h6
`define ALU_DIV_STEPS     6'h20

`endif

// >>> design/alu_pkg.sv
package alu_pkg;

	typedef enum logic [1:0] {
		sz_byte = 2'h0,
		sz_word = 2'h1,
		sz_long = 2'h2
	} alu_size_t;

	typedef enum logic [4:0] {
		op_add                = 5'h00,
		op_sub                = 5'h01,
		op_add_with_carry     = 5'h02,
		op_sub_with_carry     = 5'h03,
		op_incr               = 5'h04,
		op_decr_op            = 5'h05,
		op_fixed_step_add     = 5'h06,
		op_fixed_step_sub     = 5'h07,
		op_decimal_adjust_add = 5'h08,
		op_decimal_adjust_sub = 5'h09,
		op_unsigned_multiply  = 5'h0A,
		op_signed_multiply    = 5'h0B,
		op_unsigned_divide    = 5'h0C,
		op_signed_divide      = 5'h0D,
		op_compare_op         = 5'h0E,
		op_negate             = 5'h0F,
		op_zero_extend        = 5'h10,
		op_sign_extend        = 5'h11,
		op_and                = 5'h12,
		op_or                 = 5'h13,
		op_xor                = 5'h14,
		op_invert             = 5'h15
	} alu_op_t;

	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} alu_flags_t;

	typedef struct packed {
		alu_op_t     op;
		alu_size_t   size;
		logic        use_imm;
		logic [1:0]  step;
		logic [31:0] dst;
		logic [31:0] src;
		logic [31:0] imm;
	} alu_req_t;

	typedef struct packed {
		logic        wr_en;
		logic [31:0] result;
		alu_flags_t  flags;
	} alu_rsp_t;

	typedef enum logic {
		st_idle = 1'b0,
		st_div  = 1'b1
	} alu_main_st_t;

	typedef enum logic [1:0] {
		dv_idle = 2'h0,
		dv_run  = 2'h1,
		dv_done = 2'h3
	} alu_div_st_t;

endpackage

// >>> design/alu_addsub.sv
`timescale 1ns/1ps
module alu_addsub
	import alu_pkg::*;
(
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	input  wire logic        sub,
	input  wire logic        cin,
	input  wire logic [4:0]  sh,
	output logic [31:0]      res,
	output alu_flags_t       fl
);

	logic [31:0] aa;
	logic [31:0] bb;
	logic [32:0] sum;

	// Operands are moved to the top of the word so that carry, overflow and
	// half carry sit at the same bit positions for every operand size.
	always_comb begin
		aa = a << sh;
		bb = (sub ? ~b : b) << sh;
		sum = {1'b0, aa} + {1'b0, bb} + ({32'h0, cin ^ sub} << sh);
		res = sum[31:0] >> sh;
		fl.c = sum[32] ^ sub;
		fl.h = sum[28] ^ aa[28] ^ bb[28] ^ sub;
		fl.v = (aa[31] == bb[31]) && (sum[31] != aa[31]);
		fl.n = sum[31];
		fl.z = (res == 32'h0);
	end

endmodule // alu_addsub

// >>> design/alu_div.sv
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_div
	import alu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic [31:0] dividend,
	input  wire logic [15:0] divisor,
	output logic             busy,
	output logic             done,
	output logic [31:0]      quot,
	output logic [15:0]      rem
);

	alu_div_st_t st_q, st_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [31:0] q_q, q_d;
	logic [15:0] r_q, r_d;
	logic [15:0] d_q, d_d;
	logic [17:0] trial;

	// Restoring division, one quotient bit per clock. A zero divisor gives
	// an all-ones quotient rather than a trap.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		q_d = q_q;
		r_d = r_q;
		d_d = d_q;
		trial = {1'b0, r_q, q_q[31]} - {2'h0, d_q};
		case (st_q)
			dv_idle: if (start) begin
				st_d = dv_run;
				cnt_d = `ALU_DIV_STEPS;
				q_d = dividend;
				r_d = 16'h0000;
				d_d = divisor;
			end
			dv_run: begin
				r_d = trial[17] ? {r_q[14:0], q_q[31]} : trial[15:0];
				q_d = {q_q[30:0], ~trial[17]};
				cnt_d = cnt_q - 6'h01;
				if (cnt_q == 6'h01)
					st_d = dv_done;
			end
			dv_done: st_d = dv_idle;
			default: st_d = dv_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= dv_idle;
			cnt_q <= 6'h00;
			q_q <= 32'h0000_0000;
			r_q <= 16'h0000;
			d_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			q_q <= q_d;
			r_q <= r_d;
			d_q <= d_d;
		end
	end

	assign busy = (st_q != dv_idle);
	assign done = (st_q == dv_done);
	assign quot = q_q;
	assign rem = r_q;

	a_div_steps: assert property (@(posedge ref_clk) disable iff (!nrst)
		(start && st_q == dv_idle) |-> ##33 done)
		else $error("Divider did not finish 33 cycles after start.");

endmodule // alu_div

// >>> design/alu_top.sv
// Behaviour
// - Add and subtract at byte, word, long; register or immediate source.
// - Carry add and carry subtract are byte only and include carry.
// - Increment and decrement step one or two; byte steps one only.
// - Fixed-step add and subtract change a 32-bit register by 1, 2, 4.
// - Decimal adjust corrects a byte into two packed BCD digits using flags.
// - Unsigned multiply gives 8x8 to 16 or 16x16 to 32 bits.
// - Signed multiply treats operands as two's complement, same sizes.
// - Unsigned divide gives quotient and remainder, 16/8 or 32/16.
// - Signed divide treats operands as two's complement, same widths.
// - Compare subtracts, updates only flags, leaves register unchanged.
// - Negate replaces the value by zero minus it at any size.
// - Zero extend fills the upper half of word or long with zeros.
// - Sign extend copies the low half's top bit into the upper half.
// - Bitwise AND of register with register or immediate, any size.
// - Bitwise OR of register with register or immediate, any size.
// - Bitwise XOR of register with register or immediate, any size.
// - Invert replaces register by its one's complement, any size.
// - Flag register holds H, N, Z, V, C; arithmetic except fixed-step and unsigned multiply updates, carry ops read.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "alu_consts.svh"
module alu_top
	import alu_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire alu_req_t    req,
	output logic             rsp_valid,
	output alu_rsp_t         rsp,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] v, input alu_size_t sz);
		case (sz)
			sz_byte: merge = {old[31:8], v[7:0]};
			sz_word: merge = {old[31:16], v[15:0]};
			default: merge = v;
		endcase
	endfunction

	function automatic logic [4:0] shamt(input alu_size_t sz);
		case (sz)
			sz_byte: shamt = `ALU_SH_B;
			sz_word: shamt = `ALU_SH_W;
			default: shamt = `ALU_SH_L;
		endcase
	endfunction

	function automatic alu_flags_t set_nz(input alu_flags_t f,
		input logic [31:0] v, input alu_size_t sz);
		logic [31:0] m;
		m = merge(32'h0, v, sz);
		set_nz = f;
		set_nz.z = (m == 32'h0);
		set_nz.n = m[31 - 32'(shamt(sz))];
	endfunction

	alu_main_st_t st_q, st_d;
	alu_req_t     hold_q, hold_d;
	alu_rsp_t     rsp_q, rsp_d;
	logic         rv_q, rv_d;
	alu_flags_t   flags_q, flags_d;

	logic         aw_v_q, aw_v_d, w_v_q, w_v_d;
	logic [7:0]   aw_a_q, aw_a_d;
	logic [31:0]  w_d_q, w_d_d;
	logic [3:0]   w_s_q, w_s_d;
	logic         bv_q, bv_d, rvl_q, rvl_d;
	logic [1:0]   br_q, br_d, rr_q, rr_d;
	logic [31:0]  rd_q, rd_d;
	logic         fl_wr;
	logic [31:0]  wd;

	logic         take, is_div, sgn, div_start, div_done, div_busy;
	logic [31:0]  bop, stp, fstp, a_in, b_in, ar_res, res_v, dvd;
	logic [31:0]  quot, dres;
	logic [15:0]  dvs, rem;
	logic [4:0]   sh_in;
	logic         sub_in, cin_in, wr, hi_fix, lo_fix, dneg, sneg;
	alu_size_t    mw;
	alu_flags_t   ar_fl, fl_n, dfl;
	logic [15:0]  mu8;
	logic [31:0]  mu16;
	logic signed [15:0] ms8;
	logic signed [31:0] ms16;

	////////////////////////////////////////////////////////////////////////
	// Operand steering for the shared adder.

	assign req_ready = (st_q == st_idle);
	assign take = req_valid && req_ready;
	assign is_div = (req.op == op_unsigned_divide) ||
		(req.op == op_signed_divide);
	assign bop = req.use_imm ? req.imm : req.src;
	// Byte size ignores the step code, so a byte step is always one.
	assign stp = (req.size == sz_byte || req.step == 2'h0) ? 32'h1
		: 32'h2;
	assign fstp = (req.step == 2'h0) ? 32'h1 : (req.step == 2'h1) ? 32'h2
		: 32'h4;

	always_comb begin
		a_in = req.dst;
		b_in = bop;
		sub_in = 1'b0;
		cin_in = 1'b0;
		sh_in = shamt(req.size);
		case (req.op)
			op_sub, op_compare_op: sub_in = 1'b1;
			op_add_with_carry: begin
				sh_in = `ALU_SH_B;
				cin_in = flags_q.c;
			end
			op_sub_with_carry: begin
				sh_in = `ALU_SH_B;
				sub_in = 1'b1;
				cin_in = flags_q.c;
			end
			op_incr: b_in = stp;
			op_decr_op: begin
				b_in = stp;
				sub_in = 1'b1;
			end
			op_fixed_step_add: begin
				b_in = fstp;
				sh_in = `ALU_SH_L;
			end
			op_fixed_step_sub: begin
				b_in = fstp;
				sh_in = `ALU_SH_L;
				sub_in = 1'b1;
			end
			op_negate: begin
				a_in = 32'h0;
				b_in = req.dst;
				sub_in = 1'b1;
			end
			default: ;
		endcase
	end

	alu_addsub u_addsub (
		.a   (a_in),
		.b   (b_in),
		.sub (sub_in),
		.cin (cin_in),
		.sh  (sh_in),
		.res (ar_res),
		.fl  (ar_fl)
	);

	////////////////////////////////////////////////////////////////////////
	// Single-cycle results and their flags.

	assign mu8 = req.dst[7:0] * req.src[7:0];
	assign mu16 = req.dst[15:0] * req.src[15:0];
	assign ms8 = $signed(req.dst[7:0]) * $signed(req.src[7:0]);
	assign ms16 = $signed(req.dst[15:0]) * $signed(req.src[15:0]);

	always_comb begin
		res_v = ar_res;
		mw = req.size;
		wr = 1'b1;
		// Set on every path so that no latch is inferred for the divider.
		sgn = (req.op == op_sign_extend) || (req.op == op_signed_divide);
		fl_n = flags_q;
		hi_fix = flags_q.c || (req.dst[7:0] > `ALU_BCD_BYTE_MAX);
		lo_fix = flags_q.h || (req.dst[3:0] > `ALU_BCD_DIGIT_MAX);
		case (req.op)
			op_add, op_sub, op_negate: fl_n = ar_fl;
			op_add_with_carry, op_sub_with_carry: begin
				mw = sz_byte;
				fl_n = ar_fl;
				// Zero only survives a chain of carry operations.
				fl_n.z = ar_fl.z && flags_q.z;
			end
			op_incr, op_decr_op: begin
				fl_n.n = ar_fl.n;
				fl_n.z = ar_fl.z;
				fl_n.v = ar_fl.v;
			end
			op_fixed_step_add, op_fixed_step_sub: mw = sz_long;
			op_compare_op: begin
				wr = 1'b0;
				fl_n = ar_fl;
			end
			op_decimal_adjust_add: begin
				mw = sz_byte;
				res_v = {24'h0, req.dst[7:0] + {hi_fix ? `ALU_BCD_FIX : 4'h0,
					lo_fix ? `ALU_BCD_FIX : 4'h0}};
				fl_n = set_nz(flags_q, res_v, sz_byte);
				fl_n.c = hi_fix;
			end
			op_decimal_adjust_sub: begin
				mw = sz_byte;
				res_v = {24'h0, req.dst[7:0] - {flags_q.c ? `ALU_BCD_FIX
					: 4'h0, flags_q.h ? `ALU_BCD_FIX : 4'h0}};
				fl_n = set_nz(flags_q, res_v, sz_byte);
			end
			op_unsigned_multiply: begin
				mw = (req.size == sz_byte) ? sz_word : sz_long;
				res_v = (req.size == sz_byte) ? {16'h0, mu8} : mu16;
			end
			op_signed_multiply: begin
				mw = (req.size == sz_byte) ? sz_word : sz_long;
				res_v = (req.size == sz_byte) ? {16'h0, ms8} : ms16;
				fl_n = set_nz(flags_q, res_v, mw);
			end
			op_zero_extend, op_sign_extend: begin
				if (req.size == sz_word)
					res_v = {16'h0, {8{sgn && req.dst[7]}}, req.dst[7:0]};
				else
					res_v = {{16{sgn && req.dst[15]}}, req.dst[15:0]};
				fl_n = set_nz(flags_q, res_v, req.size);
				fl_n.v = 1'b0;
			end
			op_and, op_or, op_xor, op_invert: begin
				case (req.op)
					op_and: res_v = req.dst & bop;
					op_or: res_v = req.dst | bop;
					op_xor: res_v = req.dst ^ bop;
					default: res_v = ~req.dst;
				endcase
				fl_n = set_nz(flags_q, res_v, req.size);
				fl_n.v = 1'b0;
			end
			default: wr = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Divide: magnitudes go to the divider, signs are restored afterwards.

	always_comb begin
		if (req.size == sz_byte) begin
			dvd = {16'h0, (sgn && req.dst[15]) ? ~req.dst[15:0] + 16'h1
				: req.dst[15:0]};
			dvs = {8'h0, (sgn && req.src[7]) ? ~req.src[7:0] + 8'h1
				: req.src[7:0]};
		end else begin
			dvd = (sgn && req.dst[31]) ? ~req.dst + 32'h1 : req.dst;
			dvs = (sgn && req.src[15]) ? ~req.src[15:0] + 16'h1
				: req.src[15:0];
		end
		dneg = (hold_q.op == op_signed_divide) && ((hold_q.size == sz_byte)
			? hold_q.dst[15] : hold_q.dst[31]);
		sneg = (hold_q.op == op_signed_divide) && ((hold_q.size == sz_byte)
			? hold_q.src[7] : hold_q.src[15]);
		dres = quot;
		if (dneg ^ sneg)
			dres = ~quot + 32'h1;
		if (hold_q.size == sz_byte)
			dres = {16'h0, dneg ? ~rem[7:0] + 8'h1 : rem[7:0], dres[7:0]};
		else
			dres = {dneg ? ~rem + 16'h1 : rem, dres[15:0]};
		dfl = flags_q;
		dfl.n = (hold_q.size == sz_byte) ? dres[7] : dres[15];
		dfl.z = (hold_q.size == sz_byte) ? (hold_q.src[7:0] == 8'h00)
			: (hold_q.src[15:0] == 16'h0000);
	end

	alu_div u_div (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.start    (div_start),
		.dividend (dvd),
		.divisor  (dvs),
		.busy     (div_busy),
		.done     (div_done),
		.quot     (quot),
		.rem      (rem)
	);

	////////////////////////////////////////////////////////////////////////
	// Request sequencing, answer register and the flag register.

	always_comb begin
		st_d = st_q;
		hold_d = hold_q;
		rsp_d = rsp_q;
		rv_d = 1'b0;
		div_start = 1'b0;
		flags_d = fl_wr ? alu_flags_t'(wd[`ALU_FLAGS_W-1:0]) : flags_q;
		// An update from an operation wins over a software write.
		case (st_q)
			st_idle: if (req_valid) begin
				hold_d = req;
				if (is_div) begin
					st_d = st_div;
					div_start = 1'b1;
				end else begin
					rv_d = 1'b1;
					rsp_d.wr_en = wr;
					rsp_d.result = wr ? merge(req.dst, res_v, mw)
						: req.dst;
					rsp_d.flags = fl_n;
					flags_d = fl_n;
				end
			end
			st_div: if (div_done) begin
				st_d = st_idle;
				rv_d = 1'b1;
				rsp_d.wr_en = 1'b1;
				rsp_d.result = merge(hold_q.dst, dres,
					(hold_q.size == sz_byte) ? sz_word : sz_long);
				rsp_d.flags = dfl;
				flags_d = dfl;
			end
			default: st_d = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= st_idle;
			hold_q <= '0;
			rsp_q <= '0;
			rv_q <= 1'b0;
			flags_q <= alu_flags_t'(`ALU_FLAGS_RST);
		end else begin
			st_q <= st_d;
			hold_q <= hold_d;
			rsp_q <= rsp_d;
			rv_q <= rv_d;
			flags_q <= flags_d;
		end
	end

	assign rsp_valid = rv_q;
	assign rsp = rsp_q;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: flags read/write, last result and status read only.

	assign s_axi_awready = !aw_v_q && !bv_q;
	assign s_axi_wready = !w_v_q && !bv_q;
	assign s_axi_arready = !rvl_q;

	always_comb begin
		aw_v_d = aw_v_q || (s_axi_awvalid && s_axi_awready);
		aw_a_d = aw_v_q ? aw_a_q : s_axi_awaddr;
		w_v_d = w_v_q || (s_axi_wvalid && s_axi_wready);
		w_d_d = w_v_q ? w_d_q : s_axi_wdata;
		w_s_d = w_v_q ? w_s_q : s_axi_wstrb;
		wd = w_d_d;
		bv_d = bv_q && !s_axi_bready;
		br_d = br_q;
		fl_wr = 1'b0;
		if (aw_v_d && w_v_d && !bv_q) begin
			aw_v_d = 1'b0;
			w_v_d = 1'b0;
			bv_d = 1'b1;
			br_d = (aw_a_d == `ALU_OFS_FLAGS) ? `ALU_RESP_OKAY
				: `ALU_RESP_SLVERR;
			fl_wr = (aw_a_d == `ALU_OFS_FLAGS) && w_s_d[0];
		end
		rvl_d = rvl_q && !s_axi_rready;
		rd_d = rd_q;
		rr_d = rr_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvl_d = 1'b1;
			rr_d = `ALU_RESP_OKAY;
			rd_d = 32'h0;
			case (s_axi_araddr)
				`ALU_OFS_FLAGS: rd_d[`ALU_FLAGS_W-1:0] = flags_q;
				`ALU_OFS_RESULT: rd_d = rsp_q.result;
				`ALU_OFS_STATUS: rd_d[`ALU_STAT_BUSY] = div_busy;
				default: rr_d = `ALU_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_v_q <= 1'b0;
			aw_a_q <= 8'h00;
			w_v_q <= 1'b0;
			w_d_q <= 32'h0000_0000;
			w_s_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= 2'h0;
			rvl_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			rr_q <= 2'h0;
		end else begin
			aw_v_q <= aw_v_d;
			aw_a_q <= aw_a_d;
			w_v_q <= w_v_d;
			w_d_q <= w_d_d;
			w_s_q <= w_s_d;
			bv_q <= bv_d;
			br_q <= br_d;
			rvl_q <= rvl_d;
			rd_q <= rd_d;
			rr_q <= rr_d;
		end
	end

	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_rvalid = rvl_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_plain_take;
		take && !is_div;
	endsequence
	sequence s_div_take;
		take && is_div;
	endsequence
	sequence s_div_wait;
		!rsp_valid [*8] ##26 rsp_valid;
	endsequence

	a_plain_answer: assert property (s_plain_take |=> rsp_valid)
		else $error("Single-cycle operation gave no answer.");
	a_div_answer: assert property (s_div_take |=> s_div_wait)
		else $error("Divide answer not on the 34th cycle.");
	a_add_long: assert property (take && req.op == op_add &&
		req.size == sz_long |=> rsp.result == hold_q.dst +
		(hold_q.use_imm ? hold_q.imm : hold_q.src))
		else $error("Longword add result wrong.");
	a_cmp_keeps: assert property (rsp_valid &&
		hold_q.op == op_compare_op |-> !rsp.wr_en &&
		rsp.result == hold_q.dst)
		else $error("Compare changed the register.");
	a_byte_merge: assert property (rsp_valid && hold_q.size == sz_byte &&
		hold_q.op inside {op_add, op_sub, op_and, op_or, op_xor,
		op_invert, op_negate} |-> rsp.result[31:8] == hold_q.dst[31:8])
		else $error("Byte operation touched upper bits.");
	a_step_flags: assert property (take && req.op inside
		{op_fixed_step_add, op_fixed_step_sub} |=> $stable(flags_q))
		else $error("Fixed-step operation changed flags.");
	a_neg_long: assert property (take && req.op == op_negate &&
		req.size == sz_long |=> rsp.result == 32'h0 - hold_q.dst &&
		rsp.flags.c == (hold_q.dst != 32'h0))
		else $error("Negate result or borrow wrong.");
	a_mulu_word: assert property (take &&
		req.op == op_unsigned_multiply && req.size == sz_word |=>
		rsp.result == hold_q.dst[15:0] * hold_q.src[15:0])
		else $error("Unsigned word multiply wrong.");
	a_sext_word: assert property (take && req.op == op_sign_extend &&
		req.size == sz_word |=> rsp.result[15:8] == {8{hold_q.dst[7]}}
		&& rsp.result[31:16] == hold_q.dst[31:16])
		else $error("Sign extension to word wrong.");
	a_carry_add: assert property (take &&
		req.op == op_add_with_carry |=> rsp.result[7:0] ==
		8'(hold_q.dst[7:0] + (hold_q.use_imm ? hold_q.imm[7:0]
		: hold_q.src[7:0]) + {7'h0, $past(flags_q.c)}))
		else $error("Carry add ignored the carry flag.");

endmodule // alu_top

// >>> test/alu_far_model.sv
`timescale 1ns/1ps
module alu_far_model
	import alu_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire logic     req_ready,
	input  wire logic     rsp_valid,
	input  wire alu_rsp_t rsp,
	output logic          req_valid,
	output alu_req_t      req
);
	initial begin
		req_valid = 1'b0;
		req = '0;
	end

	// Once taken, the payload is inverted so a stale request never looks live.
	task automatic issue(input alu_req_t r, output alu_rsp_t o);
		if (r.op == op_sub && r.size == sz_byte && r.use_imm) begin
			r.src = r.imm;
			r.use_imm = 1'b0;
		end
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= r;
		do @(posedge ref_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req <= ~r;
		while (rsp_valid !== 1'b1) @(posedge ref_clk);
		o = rsp;
	endtask
endmodule // alu_far_model

// >>> test/test_cpu_arith_logic_unit.sv
`timescale 1ns/1ps
module test_cpu_arith_logic_unit
	import alu_pkg::*;
;
	logic		ref_clk = 1'b0, nrst = 1'b0;
	logic		req_valid, req_ready, rsp_valid;
	alu_req_t	req;
	alu_rsp_t	rsp, o;
	logic		s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic		s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic		s_axi_rready = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0, s_axi_rdata, rd, rs;
	logic [3:0]	s_axi_wstrb = 4'h0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic		s_axi_arready, s_axi_rvalid;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	int		n_mismatch = 0, tests_run = 0;

	always #12.5 ref_clk = ~ref_clk;

	alu_top dut (.ref_clk, .nrst, .req_valid, .req_ready, .req, .rsp_valid,
		.rsp, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp);
	alu_far_model far (.ref_clk, .req_ready, .rsp_valid, .rsp, .req_valid,
		.req);

	////////////////////////////////////////////////////////////////////
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge ref_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!(aw && w));
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		rs = {30'h0, s_axi_bresp};
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = {30'h0, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Source and immediate carry the same value; use_imm picks one.
	task automatic go(input alu_op_t p, input alu_size_t z, input logic u,
		input logic [1:0] s, input logic [31:0] d, input logic [31:0] r,
		input logic [31:0] e);
		far.issue('{p, z, u, s, d, r, r}, o);
		chk(o.result, e);
	endtask

	task automatic fl(input logic [3:0] e);
		chk({28'h0, o.flags[3:0]}, {28'h0, e});
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_axi();
		axi_rd(8'h00);
		chk(rd, 32'h0);
		axi_wr(8'h00, 32'h0F);
		chk(rs, 32'h0);
		axi_wr(8'h0C, 32'h00);
		chk(rs, 32'h2);
		axi_rd(8'h00);
		chk(rd, 32'h0F);
		axi_rd(8'h0C);
		chk(rs, 32'h2);
	endtask

	task automatic t_addsub();
		go(op_add, sz_byte, 1, 0, 32'h1122337F, 32'h01, 32'h11223380);
		fl(4'hA);
		go(op_sub, sz_word, 0, 0, 32'hAAAA0005, 32'h07, 32'hAAAAFFFE);
		fl(4'h9);
		go(op_sub, sz_byte, 1, 0, 32'h10, 32'h10, 32'h00);
		fl(4'h4);
		go(op_add, sz_long, 0, 0, 32'hFFFFFFFF, 32'h01, 32'h0);
		fl(4'h5);
	endtask

	task automatic t_carry();
		axi_wr(8'h00, 32'h01);
		go(op_add_with_carry, sz_byte, 1, 0, 32'h10, 32'h20, 32'h31);
		go(op_sub_with_carry, sz_byte, 0, 0, 32'h50, 32'h20, 32'h30);
		go(op_decimal_adjust_add, sz_byte, 0, 0, 32'h3C, 0, 32'h42);
		axi_wr(8'h00, 32'h10);
		go(op_decimal_adjust_sub, sz_byte, 0, 0, 32'h1B, 0, 32'h15);
	endtask

	task automatic t_step();
		go(op_incr, sz_byte, 0, 0, 32'hAABBCCFF, 0, 32'hAABBCC00);
		go(op_decr_op, sz_word, 0, 1, 32'h12340001, 0, 32'h1234FFFF);
		go(op_fixed_step_add, sz_long, 0, 1, 32'h07, 0, 32'h09);
		go(op_fixed_step_sub, sz_long, 0, 2, 32'h02, 0, 32'hFFFFFFFE);
	endtask

	task automatic t_muldiv();
		go(op_unsigned_multiply, sz_byte, 0, 0,
			32'hDEAD00FF, 32'hFF, 32'hDEADFE01);
		go(op_unsigned_multiply, sz_word, 0, 0,
			32'h0000FFFF, 32'hFFFF, 32'hFFFE0001);
		go(op_signed_multiply, sz_byte, 0, 0,
			32'h12340080, 32'h7F, 32'h1234C080);
		go(op_signed_multiply, sz_word, 0, 0,
			32'h0000FFFE, 32'h03, 32'hFFFFFFFA);
		// The status read lands while the divider is still running.
		fork
			go(op_unsigned_divide, sz_byte, 0, 0,
				32'h12340064, 32'h07, 32'h1234020E);
			begin
				repeat (3) @(posedge ref_clk);
				axi_rd(8'h08);
			end
		join
		chk(rd, 32'h1);
		go(op_signed_divide, sz_byte, 0, 0,
			32'h1234FFF9, 32'h02, 32'h1234FFFD);
		go(op_unsigned_divide, sz_word, 0, 0,
			32'h00010000, 32'h03, 32'h00015555);
		go(op_signed_divide, sz_word, 0, 0,
			32'hFFFFFFF9, 32'h02, 32'hFFFFFFFD);
	endtask

	task automatic t_misc();
		go(op_compare_op, sz_word, 0, 0, 32'h05, 32'h07, 32'h05);
		chk({31'h0, o.wr_en}, 32'h0);
		fl(4'h9);
		go(op_negate, sz_byte, 0, 0, 32'h11223301, 0, 32'h112233FF);
		go(op_negate, sz_long, 0, 0, 32'h05, 0, 32'hFFFFFFFB);
		fl(4'h9);
		go(op_sign_extend, sz_word, 0, 0, 32'h12340080, 0, 32'h1234FF80);
		go(op_zero_extend, sz_word, 0, 0, 32'hABCD12F0, 0, 32'hABCD00F0);
		go(op_sign_extend, sz_long, 0, 0, 32'h8001, 0, 32'hFFFF8001);
		go(op_and, sz_long, 1, 0,
			32'hF0F0F0F0, 32'hFF00FF00, 32'hF000F000);
		go(op_or, sz_word, 0, 0, 32'h12340F0F, 32'hF000, 32'h1234FF0F);
		go(op_xor, sz_byte, 1, 0, 32'hAA, 32'hFF, 32'h55);
		go(op_invert, sz_long, 0, 0, 32'h0F0F0000, 0, 32'hF0F0FFFF);
		axi_rd(8'h04);
		chk(rd, 32'hF0F0FFFF);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		t_axi();
		t_addsub();
		t_carry();
		t_step();
		t_muldiv();
		t_misc();
		print_verdict();
	end

	// The tests need a few hundred cycles, so this only catches a hang.
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		print_verdict();
	end
endmodule // test_cpu_arith_logic_unit
